// >>> verilog/eq_fir_pkg.sv
/*
 * Shared constants and types for the programmable equalization filter.
 * Assumes one device clock for the register bus and the sample stream.
 */
`default_nettype none
package eq_fir_pkg;

    localparam int SAMPLE_W     = 8;
    localparam int TAPS         = 9;
    localparam int CENTER_TAP   = 4;
    localparam int COEF_W       = 18;
    localparam int SIDE_W       = 12;
    localparam int PROD_W       = SAMPLE_W + COEF_W;
    localparam int ACC_W        = 32;
    localparam int FRAC_W       = 16;
    localparam int ADDR_W       = 12;
    localparam int IDX_W        = 4;

    // Side tap weight code 0..6 selects an LSB of 2^-10 .. 2^-16
    localparam logic [2:0] MAX_WEIGHT = 3'h6;

    localparam logic [ADDR_W-1:0] CTRL_OFF    = 12'h000;
    localparam logic [ADDR_W-1:0] STAT_OFF    = 12'h004;
    localparam logic [ADDR_W-1:0] BANK_A_BASE = 12'h040;
    localparam logic [ADDR_W-1:0] BANK_B_BASE = 12'h080;

    localparam int MODE_LSB   = 0;
    localparam int MODE_W     = 2;
    localparam int SHARE_BIT  = 4;
    localparam int MERGE_BIT  = 5;
    localparam int WEIGHT_LSB = 8;
    localparam int WEIGHT_W   = 3;
    localparam int STAT_LINK_BIT  = 4;
    localparam int STAT_INPUT_BIT = 5;

    localparam logic [MODE_W-1:0] MODE_OFF = 2'h0;
    localparam logic [MODE_W-1:0] MODE_EQ  = 2'h2;
    localparam logic [COEF_W-1:0] CENTER_RST = 18'h10000;
    localparam logic [ACC_W-1:0]  ROUND_BIAS = 32'h00008000;

    typedef enum logic [1:0] {
        EQ_BYPASS = 2'b00,
        EQ_DUAL   = 2'b01,
        EQ_SINGLE = 2'b10,
        EQ_TVAR   = 2'b11
    } eq_mode_t;

    typedef struct packed {
        logic                valid;
        logic [SAMPLE_W-1:0] a;
        logic [SAMPLE_W-1:0] b;
    } sample_pair_t;

    typedef logic [TAPS-1:0][SAMPLE_W-1:0] sample_win_t;
    typedef logic [TAPS-1:0][COEF_W-1:0]   coeff_set_t;

endpackage : eq_fir_pkg
`default_nettype wire

// >>> verilog/eq_coeff_bank.sv
/*
 * One bank of nine filter coefficients, written one word at a time.
 * Assumes the writer decodes the address and gives a valid tap index.
 */
`timescale 1ns/1ps
`default_nettype none
module eq_coeff_bank
    import eq_fir_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              wr_en,
    input  wire logic [IDX_W-1:0]  wr_idx,
    input  wire logic [COEF_W-1:0] wr_data,
    output coeff_set_t             coeffs
);

    genvar k;
    generate
        for (k = 0; k < TAPS; k++) begin : g_coef
            if (k == CENTER_TAP) begin : g_center
                logic [COEF_W-1:0] tap_q;
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        tap_q <= CENTER_RST;
                    end else if (wr_en && wr_idx == IDX_W'(k)) begin
                        tap_q <= wr_data;
                    end
                end
                assign coeffs[k] = tap_q;
            end else begin : g_side
                logic [SIDE_W-1:0] tap_q;
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        tap_q <= '0;
                    end else if (wr_en && wr_idx == IDX_W'(k)) begin
                        tap_q <= wr_data[SIDE_W-1:0];
                    end
                end
                // Sign extension keeps one multiplier width for all taps
                assign coeffs[k] = {{(COEF_W-SIDE_W){tap_q[SIDE_W-1]}},
                                    tap_q};
            end
        end
    endgenerate

endmodule : eq_coeff_bank
`default_nettype wire

// >>> verilog/eq_fir_lane.sv
/*
 * Nine-tap multiply-accumulate with rounding and saturation.
 * Assumes the caller registers the result; this path is combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module eq_fir_lane
    import eq_fir_pkg::*;
(
    input  wire sample_win_t          win,
    input  wire coeff_set_t           coeffs,
    input  wire logic [WEIGHT_W-1:0]  weight,
    output logic [SAMPLE_W-1:0]       result
);

    logic signed [ACC_W-1:0] term [TAPS];
    logic        [2:0]       shift;

    // Codes above six are clamped to the finest weight
    assign shift = (weight > MAX_WEIGHT) ? 3'h0 : MAX_WEIGHT - weight;

    genvar k;
    generate
        for (k = 0; k < TAPS; k++) begin : g_tap
            logic signed [PROD_W-1:0] prod;
            assign prod = $signed(win[k]) * $signed(coeffs[k]);
            if (k == CENTER_TAP) begin : g_center
                assign term[k] = ACC_W'(prod);
            end else begin : g_side
                // Align side taps to the 2^-16 grid of the center
                assign term[k] = ACC_W'(prod) <<< shift;
            end
        end
    endgenerate

    always_comb begin
        logic signed [ACC_W-1:0] acc;
        logic signed [ACC_W-1:0] scaled;
        acc    = '0;
        scaled = '0;
        for (int i = 0; i < TAPS; i++) begin
            acc = acc + term[i];
        end
        scaled = (acc + $signed(ROUND_BIAS)) >>> FRAC_W;
        if (scaled > 32'sd127) begin
            result = 8'h7F;
        end else if (scaled < -32'sd128) begin
            result = 8'h80;
        end else begin
            result = scaled[SAMPLE_W-1:0];
        end
    end

endmodule : eq_fir_lane
`default_nettype wire

// >>> verilog/prog_eq_filter.sv
/*
 * Programmable nine-tap equalization filter between the converter cores
 * and the serial transport, with an APB register slave for its setup.
 * Assumes samples, the link mode decode and APB all share pclk; the link
 * mode inputs are static while the filter runs.
 *
 */
`timescale 1ns/1ps
`default_nettype none
module prog_eq_filter
    import eq_fir_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              link_single_channel,
    input  wire logic              single_input,
    input  wire sample_pair_t      samp_in,
    output sample_pair_t           samp_out
);

    // Register bus decode

    function automatic logic [IDX_W:0] bank_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] base
    );
        logic [ADDR_W-1:0] rel;
        rel = addr - base;
        if (addr >= base && rel[1:0] == 2'b00 &&
            rel[ADDR_W-1:2] < (ADDR_W-2)'(TAPS)) begin
            bank_hit = {1'b1, rel[IDX_W+1:2]};
        end else begin
            bank_hit = '0;
        end
    endfunction : bank_hit

    logic              access;
    logic              wr_access;
    logic [IDX_W:0]    hit_a;
    logic [IDX_W:0]    hit_b;
    logic              hit_ctrl;
    logic              hit_stat;
    logic              mapped;

    assign access    = psel && penable;
    assign wr_access = access && pwrite;
    assign hit_a     = bank_hit(paddr, BANK_A_BASE);
    assign hit_b     = bank_hit(paddr, BANK_B_BASE);
    assign hit_ctrl  = (paddr == CTRL_OFF);
    assign hit_stat  = (paddr == STAT_OFF);
    assign mapped    = hit_ctrl || hit_stat || hit_a[IDX_W] || hit_b[IDX_W];

    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    // Status is read only, so a write to it is flagged like a miss
    assign pslverr = access && (!mapped || (pwrite && hit_stat));

    // Control register

    logic [MODE_W-1:0]   mode_q;
    logic                share_q;
    logic                merge_q;
    logic [WEIGHT_W-1:0] weight_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q   <= MODE_OFF;
            share_q  <= 1'b0;
            merge_q  <= 1'b0;
            weight_q <= '0;
        end else if (wr_access && hit_ctrl) begin
            mode_q   <= pwdata[MODE_LSB +: MODE_W];
            share_q  <= pwdata[SHARE_BIT];
            merge_q  <= pwdata[MERGE_BIT];
            weight_q <= pwdata[WEIGHT_LSB +: WEIGHT_W];
        end
    end

    // Coefficient banks

    coeff_set_t coef_a;
    coeff_set_t coef_b;

    eq_coeff_bank u_bank_a (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_access && hit_a[IDX_W]),
        .wr_idx  (hit_a[IDX_W-1:0]),
        .wr_data (pwdata[COEF_W-1:0]),
        .coeffs  (coef_a)
    );

    eq_coeff_bank u_bank_b (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_access && hit_b[IDX_W]),
        .wr_idx  (hit_b[IDX_W-1:0]),
        .wr_data (pwdata[COEF_W-1:0]),
        .coeffs  (coef_b)
    );

    // Mode decode

    eq_mode_t eff_mode;

    always_comb begin
        eff_mode = EQ_BYPASS;
        if (mode_q == MODE_EQ) begin
            unique case ({share_q, merge_q})
                2'b00: begin
                    // Dual equalization only makes sense on a dual link
                    if (!link_single_channel) begin
                        eff_mode = EQ_DUAL;
                    end
                end
                2'b11: begin
                    if (link_single_channel) begin
                        eff_mode = EQ_SINGLE;
                    end
                end
                2'b01: begin
                    if (link_single_channel && !single_input) begin
                        eff_mode = EQ_TVAR;
                    end
                end
                2'b10: begin
                    eff_mode = EQ_BYPASS;
                end
            endcase
        end
    end

    // Register read data

    logic [31:0] rd_d;
    coeff_set_t  rd_bank;
    logic [IDX_W-1:0] rd_idx;

    always_comb begin
        rd_d    = '0;
        rd_bank = hit_a[IDX_W] ? coef_a : coef_b;
        rd_idx  = hit_a[IDX_W] ? hit_a[IDX_W-1:0] : hit_b[IDX_W-1:0];
        if (hit_ctrl) begin
            rd_d[MODE_LSB +: MODE_W]     = mode_q;
            rd_d[SHARE_BIT]              = share_q;
            rd_d[MERGE_BIT]              = merge_q;
            rd_d[WEIGHT_LSB +: WEIGHT_W] = weight_q;
        end else if (hit_stat) begin
            rd_d[1:0]            = eff_mode;
            rd_d[STAT_LINK_BIT]  = link_single_channel;
            rd_d[STAT_INPUT_BIT] = single_input;
        end else if (hit_a[IDX_W] || hit_b[IDX_W]) begin
            if (rd_idx == IDX_W'(CENTER_TAP)) begin
                rd_d[COEF_W-1:0] = rd_bank[rd_idx];
            end else begin
                rd_d[SIDE_W-1:0] = rd_bank[rd_idx][SIDE_W-1:0];
            end
        end
    end

    // Captured at the end of setup so the access phase reads a flop;
    // no write can land between the two, so the word is current
    logic [31:0] prdata_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_d;
        end else begin
            prdata_q <= '0;
        end
    end

    assign prdata = prdata_q;

    // Sample history, newest at index zero

    logic [SAMPLE_W-1:0] hist_a_q [TAPS];
    logic [SAMPLE_W-1:0] hist_b_q [TAPS];
    logic                hist_vld_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < TAPS; i++) begin
                hist_a_q[i] <= '0;
                hist_b_q[i] <= '0;
            end
        end else if (samp_in.valid) begin
            hist_a_q[0] <= samp_in.a;
            hist_b_q[0] <= samp_in.b;
            for (int i = 1; i < TAPS; i++) begin
                hist_a_q[i] <= hist_a_q[i-1];
                hist_b_q[i] <= hist_b_q[i-1];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_vld_q <= 1'b0;
        end else begin
            hist_vld_q <= samp_in.valid;
        end
    end

    // Tap windows: interleaved a,b,a,b in single and time varying modes, per channel otherwise.
    // In the interleaved stream b[n] follows a[n] in time.

    sample_win_t win_a;
    sample_win_t win_b;
    logic        interleave;

    assign interleave = (eff_mode == EQ_SINGLE) || (eff_mode == EQ_TVAR);

    genvar k;
    generate
        for (k = 0; k < TAPS; k++) begin : g_win
            if (k % 2 == 0) begin : g_even
                assign win_a[k] = interleave ? hist_a_q[k/2]
                                             : hist_a_q[k];
                assign win_b[k] = interleave ? hist_b_q[k/2]
                                             : hist_b_q[k];
            end else begin : g_odd
                assign win_a[k] = interleave ? hist_b_q[(k+1)/2]
                                             : hist_a_q[k];
                assign win_b[k] = interleave ? hist_a_q[(k-1)/2]
                                             : hist_b_q[k];
            end
        end
    endgenerate

    // Lane B takes bank A in single mode; in time varying mode the two
    // sample phases use the two sets in turn
    coeff_set_t lane_b_coef;
    logic [SAMPLE_W-1:0] res_a;
    logic [SAMPLE_W-1:0] res_b;

    assign lane_b_coef = (eff_mode == EQ_SINGLE) ? coef_a : coef_b;

    eq_fir_lane u_lane_a (
        .win    (win_a),
        .coeffs (coef_a),
        .weight (weight_q),
        .result (res_a)
    );

    eq_fir_lane u_lane_b (
        .win    (win_b),
        .coeffs (lane_b_coef),
        .weight (weight_q),
        .result (res_b)
    );

    // Output stage: bypass takes the same two-cycle path as the filter

    sample_pair_t out_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= '0;
        end else begin
            out_q.valid <= hist_vld_q;
            if (hist_vld_q) begin
                if (eff_mode == EQ_BYPASS) begin
                    out_q.a <= hist_a_q[0];
                    out_q.b <= hist_b_q[0];
                end else begin
                    out_q.a <= res_a;
                    out_q.b <= res_b;
                end
            end
        end
    end

    assign samp_out = out_q;

    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_in_then_hold;
        samp_in.valid ##1 (eff_mode == EQ_BYPASS)[*2];
    endsequence

    sequence s_ctrl_write(logic [1:0] sm);
        wr_access && hit_ctrl && pwdata[MODE_LSB +: MODE_W] == MODE_EQ &&
        {pwdata[SHARE_BIT], pwdata[MERGE_BIT]} == sm;
    endsequence

    chk_bypass_passes: assert property (
        (eff_mode == EQ_BYPASS) ##0 s_in_then_hold |->
            samp_out.valid && samp_out.a == $past(samp_in.a, 2) &&
            samp_out.b == $past(samp_in.b, 2))
        else $error("bypass sample not passed unchanged in two cycles");

    chk_mode_zero_off: assert property (
        (mode_q == MODE_OFF) |-> eff_mode == EQ_BYPASS)
        else $error("mode zero did not bypass");

    chk_dual_select: assert property (
        s_ctrl_write(2'b00) ##0 !link_single_channel |=>
            eff_mode == EQ_DUAL && !interleave)
        else $error("dual equalization not selected");

    chk_single_select: assert property (
        s_ctrl_write(2'b11) ##0 link_single_channel |=>
            eff_mode == EQ_SINGLE && lane_b_coef == coef_a)
        else $error("single equalization not selected");

    chk_tvar_sets: assert property (
        s_ctrl_write(2'b01) ##0 (link_single_channel && !single_input) |=>
            eff_mode == EQ_TVAR && lane_b_coef == coef_b)
        else $error("time varying mode not using both sets");

    chk_side_tap_write: assert property (
        wr_access && paddr == BANK_B_BASE |=>
            coef_b[0] == COEF_W'($signed($past(pwdata[SIDE_W-1:0]))))
        else $error("side tap not stored as 12 bits");

    chk_center_write: assert property (
        wr_access && paddr == BANK_A_BASE + 12'h010 |=>
            coef_a[CENTER_TAP] == $past(pwdata[COEF_W-1:0]))
        else $error("center tap not stored as 18 bits");

    chk_weight_write: assert property (
        wr_access && hit_ctrl |=>
            weight_q == $past(pwdata[WEIGHT_LSB +: WEIGHT_W]))
        else $error("weight setting not taken");

    chk_out_latency: assert property (
        samp_in.valid |-> ##2 samp_out.valid)
        else $error("output valid not two cycles after input");

    chk_unmapped_err: assert property (
        access && !mapped |-> pslverr && pready)
        else $error("unmapped access not flagged");

endmodule : prog_eq_filter
`default_nettype wire

// >>> verification/core_stream_model.sv
/*
 * Behavioural stand-in for the converter cores feeding the filter.
 * Assumes the bench gates it with run; slow thins out the valid beats.
 */
`timescale 1ns/1ps
`default_nettype none
module core_stream_model
    import eq_fir_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   run,
    input  wire logic   slow,
    output var  sample_pair_t samp
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp <= '0;
        end else if (run && (!slow || $urandom_range(3) == 0)) begin
            samp.valid <= 1'b1;
            samp.a     <= 8'($urandom);
            samp.b     <= 8'($urandom);
        end else begin
            // Idle data flips so stale samples never look valid
            samp.valid <= 1'b0;
            samp.a     <= ~samp.a;
            samp.b     <= ~samp.b;
        end
    end
endmodule : core_stream_model
`default_nettype wire

// >>> verification/testbench.sv
/*
 * Self-checking bench for the equalization filter: APB setup, random
 * coefficients and samples, a reference filter predicting each output.
 * Assumes zero-wait APB and a two-edge sample latency.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import eq_fir_pkg::*;
;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              link;
    logic              si;
    logic              run;
    logic              slow;
    sample_pair_t      samp_in;
    sample_pair_t      samp_out;
    sample_pair_t      pe [2];
    logic [31:0]       rd_q;
    logic              er_q;
    logic [31:0]       ctrl;
    logic [17:0]       ca [9];
    logic [17:0]       cb [9];
    int                ah [9];
    int                bh [9];
    int                err_count;
    int                cmp_count;
    int                k;
    int                i;
    logic [31:0] cfg_c [8] = '{32'h30, 32'h232, 32'h422, 32'h622,
                               32'h502, 32'h32, 32'h233, 32'h112};
    logic [1:0]  cfg_l [8] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h0, 2'h2,
                               2'h3};

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    prog_eq_filter u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link_single_channel(link), .single_input(si), .samp_in(samp_in),
        .samp_out(samp_out));
    core_stream_model u_core (.pclk(pclk), .presetn(presetn), .run(run),
        .slow(slow), .samp(samp_in));

    function automatic eq_mode_t eff_mode(input logic [31:0] c,
                                          input logic l, input logic s);
        if (c[1:0] != MODE_EQ) return EQ_BYPASS;
        case ({c[SHARE_BIT], c[MERGE_BIT]})
            2'b00:   return l ? EQ_BYPASS : EQ_DUAL;
            2'b11:   return l ? EQ_SINGLE : EQ_BYPASS;
            2'b01:   return (l && !s) ? EQ_TVAR : EQ_BYPASS;
            default: return EQ_BYPASS;
        endcase
    endfunction : eff_mode

    function automatic logic [7:0] fir(input int x [9], input logic useb);
        longint      acc;
        int          j;
        int          sh;
        logic [17:0] c;
        sh  = (ctrl[10:8] > MAX_WEIGHT) ? 0 : 6 - int'(ctrl[10:8]);
        acc = 0;
        for (j = 0; j < TAPS; j++) begin
            c = useb ? cb[j] : ca[j];
            if (j == CENTER_TAP) begin
                acc += longint'(c) * x[j];
            end else begin
                acc += (longint'($signed(c[11:0])) * x[j]) <<< sh;
            end
        end
        acc = (acc + 32768) >>> 16;
        if (acc > 127) acc = 127;
        else if (acc < -128) acc = -128;
        return 8'(acc);
    endfunction : fir

    function automatic sample_pair_t predict();
        sample_pair_t r;
        int           xa [9];
        int           xb [9];
        int           j;
        eq_mode_t     m;
        m = eff_mode(ctrl, link, si);
        r.valid = 1'b1;
        r.a = 8'(ah[0]);
        r.b = 8'(bh[0]);
        for (j = 0; j < TAPS; j++) begin
            xa[j] = (m == EQ_DUAL) ? ah[j] : (j % 2 == 0) ? ah[j / 2] : bh[(j + 1) / 2];
            xb[j] = (m == EQ_DUAL) ? bh[j] : (j % 2 == 0) ? bh[j / 2] : ah[(j - 1) / 2];
        end
        if (m != EQ_BYPASS) begin
            r.a = fir(xa, 1'b0);
            r.b = fir(xb, m != EQ_SINGLE);
        end
        return r;
    endfunction : predict

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: reg %h, want %h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_smp(input sample_pair_t got, input sample_pair_t exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: sample %h, want %h", $time, got, exp);
        end
    endtask : cmp_smp

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        er_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        cmp_reg({31'h0, er_q}, 32'h0);
    endtask : wr_reg

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                          input logic ee);
        apb(1'b0, a, 32'h0);
        cmp_reg(rd_q, e);
        cmp_reg({31'h0, er_q}, {31'h0, ee});
    endtask : rd_chk

    // Center kept below 2.0: its sign reading is left open
    task automatic load(input logic chk);
        int                j;
        logic [31:0]       v;
        logic [31:0]       e;
        logic [ADDR_W-1:0] a;
        for (j = 0; j < 2 * TAPS; j++) begin
            v = $urandom;
            v[17] = 1'b0;
            e = (j % TAPS == CENTER_TAP) ? {14'h0, v[17:0]} : {20'h0, v[11:0]};
            a = ((j < TAPS) ? BANK_A_BASE : BANK_B_BASE) + ADDR_W'(4 * (j % TAPS));
            if (j < TAPS) ca[j % TAPS] = e[17:0];
            else cb[j % TAPS] = e[17:0];
            wr_reg(a, v);
            if (chk) rd_chk(a, e, 1'b0);
        end
    endtask : load

    task automatic stream(input int n, input logic s);
        @(posedge pclk);
        run  <= 1'b1;
        slow <= s;
        repeat (n) @(posedge pclk);
        run <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : stream

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // Reference history never flushed, matching the design on mode changes
    always @(posedge pclk) begin
        if (presetn === 1'b1) begin
            if (pe[1].valid || samp_out.valid !== 1'b0) begin
                cmp_smp(samp_out, pe[1]);
            end
            pe[1] = pe[0];
            pe[0] = '0;
            if (samp_in.valid === 1'b1) begin
                for (k = TAPS - 1; k > 0; k--) begin
                    ah[k] = ah[k - 1];
                    bh[k] = bh[k - 1];
                end
                ah[0] = int'($signed(samp_in.a));
                bh[0] = int'($signed(samp_in.b));
                pe[0] = predict();
            end
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        $display("wrong value at %0t: run did not finish", $time);
        end_of_test();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, link, si, run, slow} = '0;
        {err_count, cmp_count, ctrl} = '0;
        pe = '{default: '0};
        ah = '{default: 0};
        bh = '{default: 0};
        presetn = 1'b0;
        rd_q = $urandom(32'h30B67454);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(CTRL_OFF, 32'h0, 1'b0);
        rd_chk(STAT_OFF, 32'h0, 1'b0);
        for (i = 0; i < TAPS; i++) begin
            rd_chk(BANK_A_BASE + ADDR_W'(4 * i), (i == CENTER_TAP) ? 32'(CENTER_RST) : 32'h0, 1'b0);
            rd_chk(BANK_B_BASE + ADDR_W'(4 * i), (i == CENTER_TAP) ? 32'(CENTER_RST) : 32'h0, 1'b0);
        end
        rd_chk(BANK_A_BASE + 12'h24, 32'h0, 1'b1);
        rd_chk(12'h100, 32'h0, 1'b1);
        apb(1'b1, BANK_B_BASE + 12'h3C, 32'hFFF);
        cmp_reg({31'h0, er_q}, 32'h1);
        apb(1'b1, STAT_OFF, 32'hFFFFFFFF);
        cmp_reg({31'h0, er_q}, 32'h1);
        rd_chk(STAT_OFF, 32'h0, 1'b0);
        load(1'b1);
        $display("test reset and registers done, mismatches %0d", err_count);
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            ctrl = (i < 8) ? cfg_c[i] : 32'h2 | (32'(i - 8) << 8);
            link <= (i < 8) ? cfg_l[i][1] : 1'b0;
            si   <= (i < 8) ? cfg_l[i][0] : 1'b0;
            wr_reg(CTRL_OFF, ctrl);
            rd_chk(CTRL_OFF, ctrl & 32'h733, 1'b0);
            rd_chk(STAT_OFF, {26'h0, si, link, 2'b00, eff_mode(ctrl, link, si)}, 1'b0);
            load(1'b0);
            stream(40, i[0]);
            $display("test mode %0d done, mismatches %0d", i, err_count);
        end
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
